// [design/axis_readback_params.svh]
// register offsets, field positions and reset values of the axis readback bank
// assumes a 32-bit classic wishbone slave with word-aligned registers
`ifndef AXIS_READBACK_PARAMS_SVH
`define AXIS_READBACK_PARAMS_SVH
`define CAUSE_STATUS_OFS   8'h00
`define LEVELS_FIRST_OFS   8'h04
`define LEVELS_SECOND_OFS  8'h08
`define READ_LOW_OFS       8'h0c
`define READ_HIGH_OFS      8'h10
`define AXIS_SELECT_OFS    8'h14
`define INT_ENABLE_OFS     8'h18
`define DATA_READ_CMD_OFS  8'h1c
`define CAUSE_PULSE_BIT    0
`define CAUSE_USED_MASK    16'h03ff
`define INT_ENABLE_RESET   16'h0000
`define AXIS_SELECT_RESET  2'h0
`endif

// [design/axis_readback_pkg.sv]
// types shared by the axis readback bank
// assumes nothing beyond the params header
package axis_readback_pkg;
   typedef logic [1:0] axis_idx_t;
   // bit 0 first: general inputs 0..3, external plus/minus, in-position, alarm
   typedef struct packed {
      logic servo_alarm_input;
      logic in_position_input;
      logic external_minus_input;
      logic external_plus_input;
      logic general_input_3;
      logic general_input_2;
      logic general_input_1;
      logic general_input_0;
   } axis_pins_t;
   // bit 1..9 causes, bit 0 unused (taken from the drive pulse edge)
   typedef logic [9:0] cause_events_t;
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [7:0]  adr;
      logic [31:0] dat;
   } wb_req_t;
endpackage : axis_readback_pkg

// [design/axis_status_readback_regs.sv]
// readback bank of a four-axis pulse controller: cause flags, pin levels, data read
// assumes a classic wishbone master, synchronous inputs, one clock
`timescale 1ns/1ps
`include "axis_readback_params.svh"

module axis_status_readback_regs #(
   parameter int AXES = 4
) (
   // clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   // wishbone slave
   input  wire logic                          cyc_i,
   input  wire logic                          stb_i,
   input  wire logic                          we_i,
   input  wire logic [3:0]                    sel_i,
   input  wire logic [7:0]                    adr_i,
   input  wire logic [31:0]                   dat_i,
   output logic      [31:0]                   dat_o,
   output logic                               ack_o,
   // per-axis events and pins
   input  wire logic [AXES-1:0]               drive_pulse_i,
   input  wire axis_readback_pkg::cause_events_t [AXES-1:0] events_i,
   input  wire axis_readback_pkg::axis_pins_t   [AXES-1:0] pins_i,
   // internal values offered to the data read command
   input  wire logic [AXES-1:0][31:0]         values_i,
   // interrupt
   output logic                               interrupt_out_n
);

   axis_readback_pkg::wb_req_t   req;
   axis_readback_pkg::axis_idx_t axis_sel_q;
   logic [AXES-1:0][15:0]        status_q;
   logic [AXES-1:0][15:0]        enable_q;
   logic [AXES-1:0]              pulse_q;
   logic [31:0]                  read_word_q;
   logic                         ack_q;
   logic [31:0]                  dat_q;
   logic                         access;
   logic                         wr;
   logic                         rd;
   logic [31:0]                  rd_value;

   assign req    = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i, adr: adr_i, dat: dat_i};
   assign access = req.cyc && req.stb && !ack_q;
   assign wr     = access && req.we;
   assign rd     = access && !req.we;
   assign ack_o  = ack_q;
   assign dat_o  = dat_q;

   // single wait state: ack one edge after the request, dropped the next
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= access;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         axis_sel_q <= `AXIS_SELECT_RESET;
      end else if (wr && req.adr == `AXIS_SELECT_OFS && req.sel[0]) begin
         axis_sel_q <= req.dat[1:0];
      end
   end

   // enables are per axis, written through the currently selected axis
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enable_q <= '{default: `INT_ENABLE_RESET};
      end else if (wr && req.adr == `INT_ENABLE_OFS) begin
         if (req.sel[0]) begin
            enable_q[axis_sel_q][7:0] <= req.dat[7:0];
         end
         if (req.sel[1]) begin
            enable_q[axis_sel_q][15:8] <= req.dat[15:8] & 8'(`CAUSE_USED_MASK >> 8);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pulse_q <= '0;
      end else begin
         pulse_q <= drive_pulse_i;
      end
   end

   // a set in the same cycle as the clearing read survives
   generate
      for (genvar a = 0; a < AXES; a++) begin : g_axis
         logic [15:0] cause;
         logic        clr;
         assign cause = {6'h00, events_i[a][9:1], drive_pulse_i[a] && !pulse_q[a]};
         // clear needs the low byte; a byte-wide master hits it with the low lane
         assign clr = rd && req.adr == `CAUSE_STATUS_OFS && req.sel[0]
                      && axis_sel_q == 2'(a);
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               status_q[a] <= 16'h0000;
            end else begin
               status_q[a] <= ((clr ? 16'h0000 : status_q[a])
                               | (cause & enable_q[a])) & `CAUSE_USED_MASK;
            end
         end
      end
   endgenerate

   // snapshot keeps both words coherent even while the source moves
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         read_word_q <= 32'h0000_0000;
      end else if (wr && req.adr == `DATA_READ_CMD_OFS) begin
         read_word_q <= values_i[axis_sel_q];
      end
   end

   always_comb begin
      rd_value = 32'h0000_0000;
      case (req.adr)
         `CAUSE_STATUS_OFS:  rd_value = {16'h0000, status_q[axis_sel_q]};
         `LEVELS_FIRST_OFS:  rd_value = {16'h0000, pins_i[1], pins_i[0]};
         `LEVELS_SECOND_OFS: rd_value = {16'h0000, pins_i[3], pins_i[2]};
         `READ_LOW_OFS:      rd_value = {16'h0000, read_word_q[15:0]};
         `READ_HIGH_OFS:     rd_value = {16'h0000, read_word_q[31:16]};
         `AXIS_SELECT_OFS:   rd_value = {30'h0000_0000, axis_sel_q};
         `INT_ENABLE_OFS:    rd_value = {16'h0000, enable_q[axis_sel_q]};
         default:            rd_value = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= 32'h0000_0000;
      end else if (rd) begin
         dat_q <= rd_value;
      end
   end

   // active low level while any flag of any axis is pending
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         interrupt_out_n <= 1'b1;
      end else begin
         interrupt_out_n <= ~|status_q;
      end
   end

   sequence status_read_s;
      rd && req.adr == `CAUSE_STATUS_OFS && req.sel[0];
   endsequence

   sequence quiet_s;
      (events_i == '0) && (drive_pulse_i == pulse_q);
   endsequence

   ack_follows_a: assert property (@(posedge clk_i) disable iff (rst_i)
      access |=> ack_o ##1 !ack_o)
      else $error("ack not given one cycle after request");

   ack_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |-> $past(access))
      else $error("ack without request");

   read_clears_a: assert property (@(posedge clk_i) disable iff (rst_i)
      status_read_s and quiet_s |=> status_q[$past(axis_sel_q)] == 16'h0000)
      else $error("status read did not clear");

   irq_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (status_q == '0) ##1 (status_q == '0) |=> interrupt_out_n)
      else $error("interrupt held with no flag");

   pulse_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ($rose(drive_pulse_i[0]) && enable_q[0][0]) |=> status_q[0][0] ##1 !interrupt_out_n)
      else $error("pulse edge did not flag");

   disabled_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (status_q[0][9] == 1'b0 && !enable_q[0][9]) |=> status_q[0][9] == 1'b0)
      else $error("disabled cause set its flag");

   reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      status_q[axis_sel_q][15:10] == 6'h00)
      else $error("reserved cause bits set");

   levels_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd && req.adr == `LEVELS_FIRST_OFS) |=> dat_o[15:0] == $past({pins_i[1], pins_i[0]}))
      else $error("first level word wrong");

   data_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && req.adr == `DATA_READ_CMD_OFS) |=> read_word_q == $past(values_i[axis_sel_q]))
      else $error("data read command not captured");

endmodule : axis_status_readback_regs

// [test/axis_source_model.sv]
// model of the motion core beside the readback bank: cause pulses, pin levels, values
// assumes go_i and cause_i change just after a rising edge of clk_i
`timescale 1ns/1ps
module axis_source_model (
   // clock
   input  wire logic                              clk_i,
   // control from the bench
   input  wire logic [3:0]                        go_i,
   input  wire logic [9:0]                        cause_i,
   // toward the bank
   output logic [3:0]                             pulse_o,
   output axis_readback_pkg::cause_events_t [3:0] events_o,
   output axis_readback_pkg::axis_pins_t [3:0]    pins_o,
   output logic [3:0][31:0]                       values_o
);
   // causes last one cycle; the drive pulse rises once and falls again
   always_ff @(posedge clk_i) begin
      for (int a = 0; a < 4; a++) begin
         events_o[a] <= go_i[a] ? cause_i : 10'h000;
         pulse_o[a]  <= go_i[a] & cause_i[0];
      end
   end
   // distinct levels per axis so swapped bytes show up
   assign pins_o   = 32'h7e81_3ca5;
   assign values_o = {32'hffff_ff9c, 32'h1234_5678, 32'h0001_8000, 32'h7fff_0001};
endmodule : axis_source_model

// [test/test_axis_status_readback_regs.sv]
// self-checking bench of the axis readback bank
// assumes the motion core model and a one-cycle wishbone answer
`timescale 1ns/1ps
module test_axis_status_readback_regs;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0, bsel = 4'hf;
   logic [31:0] dat = 32'h0, dat_o, rd;
   logic        ack_o, int_n;
   logic [3:0]  go = 4'h0, pulse;
   logic [9:0]  cause = 10'h000;
   axis_readback_pkg::cause_events_t [3:0] ev;
   axis_readback_pkg::axis_pins_t [3:0]    pins;
   logic [3:0][31:0] vals;
   int n_fail = 0, samples_checked = 0;
   always #20 clk_i = ~clk_i;
   axis_source_model axis_source_model_i (.clk_i(clk_i), .go_i(go), .cause_i(cause),
      .pulse_o(pulse), .events_o(ev), .pins_o(pins), .values_o(vals));
   axis_status_readback_regs axis_status_readback_regs_i (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .sel_i(sel), .adr_i(adr), .dat_i(dat),
      .dat_o(dat_o), .ack_o(ack_o), .drive_pulse_i(pulse), .events_i(ev), .pins_i(pins),
      .values_i(vals), .interrupt_out_n(int_n));
   task close_out;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // one classic cycle; read data is taken at the edge that samples ack
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; sel <= bsel; adr <= a; dat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_fail++;
         close_out;
      end else begin
         rd = dat_o;
         cyc <= 1'b0; stb <= 1'b0; we <= 1'b0; sel <= 4'h0;
      end
   endtask : bus
   task t_reset;
      chk("int_n", {31'h0, int_n}, 32'h1);
      bus(1'b0, 8'h00, 32'h0);
      chk("status", rd, 32'h0);
      bus(1'b0, 8'h20, 32'h0);
      chk("unmapped", rd, 32'h0);
   endtask : t_reset
   task t_levels;
      bus(1'b0, 8'h04, 32'h0);
      chk("levels01", rd, 32'h0000_3ca5);
      bus(1'b0, 8'h08, 32'h0);
      chk("levels23", rd, 32'h0000_7e81);
   endtask : t_levels
   task t_data;
      for (int a = 0; a < 4; a++) begin
         bus(1'b1, 8'h14, 32'(a));
         bus(1'b1, 8'h1c, 32'h0);
         bus(1'b0, 8'h0c, 32'h0);
         chk("read_low", rd, {16'h0, vals[a][15:0]});
         bus(1'b0, 8'h10, 32'h0);
         chk("read_high", rd, {16'h0, vals[a][31:16]});
      end
   endtask : t_data
   // causes 0, 3 and 7 on the third axis with 3 masked off
   task t_irq;
      bus(1'b1, 8'h14, 32'h2);
      bus(1'b1, 8'h18, 32'h081);
      @(posedge clk_i);
      go <= 4'h4; cause <= 10'h089;
      @(posedge clk_i);
      go <= 4'h0;
      repeat (4) @(posedge clk_i);
      chk("int_n", {31'h0, int_n}, 32'h0);
      bus(1'b1, 8'h14, 32'h1);
      bus(1'b0, 8'h00, 32'h0);
      chk("other_axis", rd, 32'h0);
      chk("int_n", {31'h0, int_n}, 32'h0);
      bus(1'b1, 8'h14, 32'h2);
      // a read without the low byte lane must leave the flags alone
      bsel = 4'he;
      bus(1'b0, 8'h00, 32'h0);
      chk("no_clear", rd, 32'h81);
      bsel = 4'hf;
      bus(1'b0, 8'h00, 32'h0);
      chk("status", rd, 32'h81);
      repeat (2) @(posedge clk_i);
      chk("int_n", {31'h0, int_n}, 32'h1);
      bus(1'b0, 8'h00, 32'h0);
      chk("cleared", rd, 32'h0);
      @(posedge clk_i);
      go <= 4'h4; cause <= 10'h008;
      @(posedge clk_i);
      go <= 4'h0;
      repeat (4) @(posedge clk_i);
      chk("masked", {31'h0, int_n}, 32'h1);
   endtask : t_irq
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_levels;
      t_data;
      t_irq;
      close_out;
   end
endmodule : test_axis_status_readback_regs
